// File: logic/timer8_pkg.sv
// Constants, field codes and mode encodings of the 8-bit timer/counter.
// Assumes every user shares one clock domain and reads names as pkg::name.
package timer8_pkg;

   // Widths
   localparam int CNT_W      = 8;
   localparam int PRESCALE_W = 10;

   // Counter landmarks and reset values
   localparam logic [7:0] BOTTOM_VAL    = 8'h00;
   localparam logic [7:0] MAX_VAL       = 8'hFF;
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [7:0] COMPARE_RESET = 8'h00;
   localparam logic [9:0] PRESCALE_RESET = 10'h000;

   // Clock select codes
   localparam logic [2:0] CS_STOP     = 3'h0;
   localparam logic [2:0] CS_DIV1     = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Prescaler tap masks
   localparam logic [9:0] MASK_DIV8    = 10'h007;
   localparam logic [9:0] MASK_DIV64   = 10'h03F;
   localparam logic [9:0] MASK_DIV256  = 10'h0FF;
   localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

   // Compare output mode codes
   localparam logic [1:0] COM_NONE   = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   // Waveform modes in encoding order 0..3
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_PC_PWM,
      MODE_CTC,
      MODE_FAST_PWM
   } wave_mode_t;

endpackage

// File: logic/timer8_link_if.sv
// Carrier between the timer core, its tick source and its compare store.
// Assumes all three sit on the same system clock.
`timescale 1ns/1ps
interface timer8_link_if;
   logic [2:0] clock_select;
   logic       tick;
   logic       cmp_wr;
   logic [7:0] cmp_wdata;
   logic       buffered;
   logic       update;
   logic [7:0] cmp_active;
   logic [7:0] cmp_buffer;

   modport tick_gen (input clock_select, output tick);
   modport store (input cmp_wr, cmp_wdata, buffered, update, output cmp_active, cmp_buffer);
   modport core (output clock_select, cmp_wr, cmp_wdata, buffered, update,
                 input tick, cmp_active, cmp_buffer);
endinterface

// File: logic/timer8_tick_source.sv
// Timer tick source: prescaled system clock or synchronised count pin.
// Assumes the count pin is asynchronous and slower than half the clock.
`timescale 1ns/1ps
module timer8_tick_source (
   // Clock and reset
   input  wire logic     clk_sys_in,
   input  wire logic     rst_n_in,
   // Count pin
   input  wire logic     ext_count_pin_in,
   // Core link
   timer8_link_if.tick_gen link
);

   logic [9:0] prescale;
   logic       pin_meta;
   logic       pin_sync;
   logic       pin_prev;
   logic       tick;

   // Prescaler runs only while a source is selected
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prescale <= timer8_pkg::PRESCALE_RESET;
      end else if (link.clock_select == timer8_pkg::CS_STOP) begin
         prescale <= timer8_pkg::PRESCALE_RESET;
      end else begin
         prescale <= prescale + 10'h001;
      end
   end

   // Two-stage pin synchroniser plus edge history
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= ext_count_pin_in;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Source and edge choice
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick <= 1'b0;
      end else begin
         case (link.clock_select)
            timer8_pkg::CS_STOP:     tick <= 1'b0;
            timer8_pkg::CS_DIV1:     tick <= 1'b1;
            timer8_pkg::CS_DIV8:     tick <= (prescale & timer8_pkg::MASK_DIV8) == timer8_pkg::MASK_DIV8;
            timer8_pkg::CS_DIV64:    tick <= (prescale & timer8_pkg::MASK_DIV64) == timer8_pkg::MASK_DIV64;
            timer8_pkg::CS_DIV256:   tick <= (prescale & timer8_pkg::MASK_DIV256) == timer8_pkg::MASK_DIV256;
            timer8_pkg::CS_DIV1024:  tick <= prescale == timer8_pkg::MASK_DIV1024;
            timer8_pkg::CS_EXT_FALL: tick <= pin_prev & ~pin_sync;
            timer8_pkg::CS_EXT_RISE: tick <= ~pin_prev & pin_sync;
            default:                 tick <= 1'b0;
         endcase
      end
   end

   assign link.tick = tick;

   property p_stop_no_tick;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      link.clock_select == timer8_pkg::CS_STOP |=> !tick;
   endproperty
   a_stop_no_tick: assert property (p_stop_no_tick) else $error("tick while stopped");

endmodule

// File: logic/timer8_compare_store.sv
// Compare value store: buffer register and active compare register.
// Assumes the core raises update only at top or bottom of the sequence.
`timescale 1ns/1ps
module timer8_compare_store (
   // Clock and reset
   input  wire logic   clk_sys_in,
   input  wire logic   rst_n_in,
   // Core link
   timer8_link_if.store link
);

   logic [7:0] cmp_active;
   logic [7:0] cmp_buffer;

   // Buffer always takes software writes
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmp_buffer <= timer8_pkg::COMPARE_RESET;
      end else if (link.cmp_wr) begin
         cmp_buffer <= link.cmp_wdata;
      end
   end

   // Active register: direct write or transfer at top
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmp_active <= timer8_pkg::COMPARE_RESET;
      end else if (link.cmp_wr && !link.buffered) begin
         cmp_active <= link.cmp_wdata;
      end else if (link.buffered && link.update) begin
         cmp_active <= cmp_buffer;
      end
   end

   assign link.cmp_active = cmp_active;
   assign link.cmp_buffer = cmp_buffer;

   property p_buffer_holds;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      link.buffered && !link.update |=> $stable(cmp_active);
   endproperty
   a_buffer_holds: assert property (p_buffer_holds) else $error("active changed off update");

   property p_direct_write;
      @(posedge clk_sys_in) disable iff (!rst_n_in)
      link.cmp_wr && !link.buffered |=> cmp_active == $past(link.cmp_wdata);
   endproperty
   a_direct_write: assert property (p_direct_write) else $error("direct write lost");

   c_update: cover property (@(posedge clk_sys_in) link.buffered && link.update);

endmodule

// File: logic/timer8_single_compare.sv
// Top of the 8-bit timer/counter with one compare unit.
// Assumes control inputs and strobes come from logic on the same clock;
// only the count pin is asynchronous.
`timescale 1ns/1ps

// Operation
// - Counter value and compare value are eight bits wide.
// - Clock select zero gives no tick; counter stays stopped.
// - Tick comes from prescaled clock or count pin, chosen with edge by clock select.
// - Bottom is flagged whenever the counter value is 0x00.
// - Maximum is flagged whenever the counter value is 0xFF.
// - Top is 0xFF or the compare value depending on mode.
// - Each tick clears, increments or decrements the counter per mode.
// - Software reads and writes the counter at any time.
// - Software counter write beats any clear or count in that cycle.
// - Counting sequence follows the two waveform mode bits.
// - Overflow flag sets at the mode's point and may request an interrupt.
// - Comparator signals match whenever counter equals compare value.
// - A match sets the compare flag on the following tick.
// - Compare interrupt needs flag, compare enable and global enable.
// - Compare flag clears when serviced or when software writes one.
// - Compare value double-buffered in PWM modes, direct otherwise.
// - Buffered value moves to active register only on a tick at top (0xFF).
// - Software compare access hits buffer when buffered, else active register.
// - Force compare in non-PWM modes drives output only, no flag, no clear.
// - Counter write blocks compare matches on the next tick, even stopped.
// - Compare output state keeps its value over mode changes.
// - Compare output mode is unbuffered and acts immediately.
// - Normal mode counts up, wraps 0xFF to 0x00, sets overflow at zero.
// - Reset forces compare output state to zero.
module timer8_single_compare (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   // Count pin
   input  wire logic       ext_count_pin_in,
   // Control fields
   input  wire logic [2:0] clock_select_in,
   input  wire logic [1:0] waveform_mode_in,
   input  wire logic [1:0] compare_output_mode_in,
   input  wire logic       force_compare_in,
   // Counter access
   input  wire logic       counter_wr_in,
   input  wire logic [7:0] counter_wdata_in,
   // Compare access
   input  wire logic       compare_wr_in,
   input  wire logic [7:0] compare_wdata_in,
   // Flag clears and interrupt service
   input  wire logic       overflow_flag_clr_in,
   input  wire logic       compare_flag_clr_in,
   input  wire logic       overflow_irq_ack_in,
   input  wire logic       compare_irq_ack_in,
   // Interrupt enables
   input  wire logic       overflow_irq_enable_in,
   input  wire logic       compare_irq_enable_in,
   input  wire logic       global_irq_enable_in,
   // Counter state
   output logic [7:0]      counter_value_out,
   output logic [7:0]      compare_value_out,
   output logic            bottom_out,
   output logic            max_out,
   // Flags and interrupts
   output logic            overflow_flag_out,
   output logic            compare_flag_out,
   output logic            overflow_irq_out,
   output logic            compare_irq_out,
   // Waveform
   output logic            compare_output_out
);

   timer8_link_if link ();

   timer8_pkg::wave_mode_t mode;
   logic [7:0]             counter_value;
   logic [7:0]             top_val;
   logic [7:0]             next_counter;
   logic                   count_down;
   logic                   next_down;
   logic                   block_match;
   logic                   overflow_flag;
   logic                   compare_flag;
   logic                   compare_output;
   logic                   next_output;
   logic                   tick;
   logic                   pwm;
   logic                   match;
   logic                   match_eff;
   logic                   ovf_evt;
   logic                   at_max;

   timer8_tick_source u_tick (
      .clk_sys_in       (clk_sys_in),
      .rst_n_in         (rst_n_in),
      .ext_count_pin_in (ext_count_pin_in),
      .link             (link)
   );

   timer8_compare_store u_store (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .link       (link)
   );

   // Mode decode
   assign mode    = timer8_pkg::wave_mode_t'(waveform_mode_in);
   assign pwm     = (mode == timer8_pkg::MODE_PC_PWM) || (mode == timer8_pkg::MODE_FAST_PWM);
   assign tick    = link.tick;
   assign at_max  = counter_value == timer8_pkg::MAX_VAL;
   assign top_val = (mode == timer8_pkg::MODE_CTC) ? link.cmp_active : timer8_pkg::MAX_VAL;

   // Comparator and blocking
   assign match     = counter_value == link.cmp_active;
   assign match_eff = tick && match && !block_match;

   // Compare store link
   assign link.clock_select = clock_select_in;
   assign link.cmp_wr       = compare_wr_in;
   assign link.cmp_wdata    = compare_wdata_in;
   assign link.buffered     = pwm;
   assign link.update       = tick && pwm && at_max;

   // Counting sequence
   always_comb begin
      next_counter = counter_value;
      next_down    = count_down;
      ovf_evt      = 1'b0;
      if (tick) begin
         case (mode)
            timer8_pkg::MODE_NORMAL: begin
               next_counter = counter_value + 8'h01;
               ovf_evt      = at_max;
               next_down    = 1'b0;
            end
            timer8_pkg::MODE_CTC: begin
               if (counter_value == top_val && !block_match) begin
                  next_counter = timer8_pkg::BOTTOM_VAL;
               end else begin
                  next_counter = counter_value + 8'h01;
               end
               ovf_evt   = at_max;
               next_down = 1'b0;
            end
            timer8_pkg::MODE_FAST_PWM: begin
               if (at_max) begin
                  next_counter = timer8_pkg::BOTTOM_VAL;
               end else begin
                  next_counter = counter_value + 8'h01;
               end
               ovf_evt   = at_max;
               next_down = 1'b0;
            end
            timer8_pkg::MODE_PC_PWM: begin
               if (!count_down) begin
                  if (at_max) begin
                     next_down    = 1'b1;
                     next_counter = counter_value - 8'h01;
                  end else begin
                     next_counter = counter_value + 8'h01;
                  end
               end else begin
                  if (counter_value == timer8_pkg::BOTTOM_VAL) begin
                     next_down    = 1'b0;
                     next_counter = counter_value + 8'h01;
                     ovf_evt      = 1'b1;
                  end else begin
                     next_counter = counter_value - 8'h01;
                  end
               end
            end
            default: begin
               next_counter = counter_value;
            end
         endcase
      end
      if (counter_wr_in) begin
         next_counter = counter_wdata_in;
         ovf_evt      = 1'b0;
      end
   end

   // Waveform generator
   always_comb begin
      next_output = compare_output;
      if (!pwm) begin
         if (match_eff || force_compare_in) begin
            case (compare_output_mode_in)
               timer8_pkg::COM_TOGGLE: next_output = ~compare_output;
               timer8_pkg::COM_CLEAR:  next_output = 1'b0;
               timer8_pkg::COM_SET:    next_output = 1'b1;
               default:                next_output = compare_output;
            endcase
         end
      end else if (mode == timer8_pkg::MODE_FAST_PWM) begin
         if (match_eff) begin
            if (compare_output_mode_in == timer8_pkg::COM_CLEAR) begin
               next_output = 1'b0;
            end else if (compare_output_mode_in == timer8_pkg::COM_SET) begin
               next_output = 1'b1;
            end
         end else if (tick && at_max) begin
            if (compare_output_mode_in == timer8_pkg::COM_CLEAR) begin
               next_output = 1'b1;
            end else if (compare_output_mode_in == timer8_pkg::COM_SET) begin
               next_output = 1'b0;
            end
         end
      end else if (match_eff) begin
         if (compare_output_mode_in == timer8_pkg::COM_CLEAR) begin
            next_output = count_down;
         end else if (compare_output_mode_in == timer8_pkg::COM_SET) begin
            next_output = ~count_down;
         end
      end
   end

   // Counter and direction
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         counter_value <= timer8_pkg::COUNTER_RESET;
         count_down    <= 1'b0;
      end else begin
         counter_value <= next_counter;
         count_down    <= next_down;
      end
   end

   // Match blocking after a counter write
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         block_match <= 1'b0;
      end else if (counter_wr_in) begin
         block_match <= 1'b1;
      end else if (tick) begin
         block_match <= 1'b0;
      end
   end

   // Overflow flag: set wins over clear
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overflow_flag <= 1'b0;
      end else if (ovf_evt) begin
         overflow_flag <= 1'b1;
      end else if (overflow_flag_clr_in || overflow_irq_ack_in) begin
         overflow_flag <= 1'b0;
      end
   end

   // Compare flag: set wins over clear
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         compare_flag <= 1'b0;
      end else if (match_eff) begin
         compare_flag <= 1'b1;
      end else if (compare_flag_clr_in || compare_irq_ack_in) begin
         compare_flag <= 1'b0;
      end
   end

   // Compare output state, untouched by mode changes
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         compare_output <= 1'b0;
      end else begin
         compare_output <= next_output;
      end
   end

   // Registered status and interrupt requests
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bottom_out        <= 1'b1;
         max_out           <= 1'b0;
         compare_value_out <= timer8_pkg::COMPARE_RESET;
         overflow_irq_out  <= 1'b0;
         compare_irq_out   <= 1'b0;
      end else begin
         bottom_out        <= next_counter == timer8_pkg::BOTTOM_VAL;
         max_out           <= next_counter == timer8_pkg::MAX_VAL;
         compare_value_out <= pwm ? link.cmp_buffer : link.cmp_active;
         overflow_irq_out  <= overflow_flag && overflow_irq_enable_in && global_irq_enable_in;
         compare_irq_out   <= compare_flag && compare_irq_enable_in && global_irq_enable_in;
      end
   end

   assign counter_value_out  = counter_value;
   assign overflow_flag_out  = overflow_flag;
   assign compare_flag_out   = compare_flag;
   assign compare_output_out = compare_output;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   property p_bottom;
      bottom_out == (counter_value == timer8_pkg::BOTTOM_VAL);
   endproperty
   a_bottom: assert property (p_bottom) else $error("bottom mismatch");

   property p_max;
      max_out == (counter_value == timer8_pkg::MAX_VAL);
   endproperty
   a_max: assert property (p_max) else $error("max mismatch");

   property p_write_wins;
      counter_wr_in |=> counter_value == $past(counter_wdata_in);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("counter write lost");

   property p_idle_holds;
      !tick && !counter_wr_in |=> $stable(counter_value);
   endproperty
   a_idle_holds: assert property (p_idle_holds) else $error("counter moved without tick");

   property p_normal_wrap;
      tick && mode == timer8_pkg::MODE_NORMAL && at_max && !counter_wr_in
      |=> counter_value == timer8_pkg::BOTTOM_VAL && overflow_flag;
   endproperty
   a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

   property p_match_flag;
      tick && match && !block_match |=> compare_flag;
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("match did not set flag");

   property p_blocked;
      tick && block_match && !compare_flag |=> !compare_flag;
   endproperty
   a_blocked: assert property (p_blocked) else $error("blocked match set flag");

   property p_irq;
      compare_flag && compare_irq_enable_in && global_irq_enable_in |=> compare_irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("compare request missing");

   property p_flag_clear;
      (compare_flag_clr_in || compare_irq_ack_in) && !match_eff |=> !compare_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("compare flag not cleared");

   property p_force;
      force_compare_in && !pwm && !tick && !counter_wr_in && !compare_flag_clr_in
      && compare_output_mode_in == timer8_pkg::COM_TOGGLE && !compare_irq_ack_in
      |=> compare_output != $past(compare_output) && $stable(compare_flag)
          && $stable(counter_value);
   endproperty
   a_force: assert property (p_force) else $error("force compare wrong");

   c_overflow: cover property (ovf_evt ##1 overflow_irq_out [*2]);
   c_ctc_clear: cover property (mode == timer8_pkg::MODE_CTC && match_eff ##1 bottom_out);
   c_pc_turn: cover property (mode == timer8_pkg::MODE_PC_PWM && tick && at_max ##1 count_down);

endmodule

// File: test/tb_timer8_single_compare.sv
// Self-checking bench for the 8-bit timer/counter with one compare unit.
// Assumes the design checks its own port timing; stimulus changes on falling edges.
`timescale 1ns/1ps
module tb_timer8_single_compare;
   logic       clk_sys_in, rst_n_in, ext_count_pin_in, force_compare_in;
   logic [2:0] clock_select_in;
   logic [1:0] waveform_mode_in, compare_output_mode_in;
   logic       counter_wr_in, compare_wr_in, overflow_flag_clr_in, compare_flag_clr_in;
   logic       overflow_irq_ack_in, compare_irq_ack_in, overflow_irq_enable_in;
   logic       compare_irq_enable_in, global_irq_enable_in;
   logic [7:0] counter_wdata_in, compare_wdata_in, counter_value_out, compare_value_out;
   logic       bottom_out, max_out, overflow_flag_out, compare_flag_out;
   logic       overflow_irq_out, compare_irq_out, compare_output_out, oc;
   int         miscompares, comparisons, seed;
   logic [7:0] d, c, top;

   timer8_single_compare timer8_single_compare_i (.*);

   initial begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   task summarize;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_sys_in);
      s = 1'b0;
   endtask

   task wr_cnt(input logic [7:0] v);
      counter_wdata_in = v;
      pulse(counter_wr_in);
   endtask

   task wr_cmp(input logic [7:0] v);
      compare_wdata_in = v;
      pulse(compare_wr_in);
   endtask

   function logic sig(input int k);
      return (k == 0) ? overflow_flag_out : (k == 1) ? compare_flag_out : max_out;
   endfunction

   function logic force_exp(input logic prev, input logic [1:0] mode);
      case (mode)
         timer8_pkg::COM_TOGGLE: return ~prev;
         timer8_pkg::COM_CLEAR:  return 1'b0;
         timer8_pkg::COM_SET:    return 1'b1;
         default:                return prev;
      endcase
   endfunction

   function int div_of(input logic [2:0] k);
      case (k)
         timer8_pkg::CS_DIV8:   return 8;
         timer8_pkg::CS_DIV64:  return 64;
         timer8_pkg::CS_DIV256: return 256;
         default:               return 1024;
      endcase
   endfunction

   task wait_sig(input int k);
      int n;
      n = 0;
      while (sig(k) !== 1'b1) begin
         n++;
         if (n > 600) begin
            miscompares++;
            $display("MISMATCH %0t wait timed out", $time);
            summarize();
         end
         @(negedge clk_sys_in);
      end
   endtask

   task done(input string name);
      $display("finished %s", name);
   endtask

   initial begin
      seed = 32'hc1801eb9;
      {rst_n_in, ext_count_pin_in, force_compare_in, clock_select_in} = '0;
      {waveform_mode_in, compare_output_mode_in, counter_wr_in, compare_wr_in} = '0;
      {overflow_flag_clr_in, compare_flag_clr_in, overflow_irq_ack_in} = '0;
      {compare_irq_ack_in, overflow_irq_enable_in, compare_irq_enable_in} = '0;
      {global_irq_enable_in, counter_wdata_in, compare_wdata_in} = '0;
      cyc(6);
      rst_n_in = 1'b1;
      cyc(1);
      chk(counter_value_out, 8'h00);
      chk(compare_value_out, 8'h00);
      chk({overflow_flag_out, compare_flag_out}, 8'h00);
      chk(compare_output_out, 8'h00);
      chk({bottom_out, max_out}, 8'h02);
      done("reset");
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
         wr_cnt(d);
         cyc(4);
         chk(counter_value_out, d);
         chk({bottom_out, max_out}, {6'h00, d == 8'h00, d == 8'hFF});
      end
      done("stopped writes");
      {overflow_irq_enable_in, global_irq_enable_in} = 2'h3;
      wr_cnt(8'hF0);
      clock_select_in = timer8_pkg::CS_DIV1;
      wait_sig(0);
      chk(counter_value_out, 8'h00);
      cyc(2);
      chk(overflow_irq_out, 8'h01);
      pulse(overflow_irq_ack_in);
      chk(overflow_flag_out, 8'h00);
      done("overflow");
      clock_select_in = timer8_pkg::CS_STOP;
      c = 8'h08 + 8'($random(seed) & 32'h3F);
      wr_cmp(c);
      pulse(compare_flag_clr_in);
      cyc(2);
      chk(compare_value_out, c);
      {compare_irq_enable_in, global_irq_enable_in} = 2'h2;
      clock_select_in = timer8_pkg::CS_DIV1;
      wait_sig(1);
      chk(counter_value_out, c + 8'h01);
      cyc(2);
      chk(compare_irq_out, 8'h00);
      global_irq_enable_in = 1'b1;
      cyc(2);
      chk(compare_irq_out, 8'h01);
      pulse(compare_flag_clr_in);
      chk(compare_flag_out, 8'h00);
      done("compare flag");
      clock_select_in = timer8_pkg::CS_STOP;
      c = 8'($random(seed));
      wr_cmp(c);
      cyc(3);
      pulse(compare_flag_clr_in);
      wr_cnt(c);
      clock_select_in = timer8_pkg::CS_DIV1;
      cyc(8);
      chk(compare_flag_out, 8'h00);
      clock_select_in = timer8_pkg::CS_STOP;
      cyc(3);
      oc = compare_output_out;
      for (int i = 0; i < 8; i++) begin
         compare_output_mode_in = (i < 4) ? 2'(i) : 2'($random(seed));
         pulse(force_compare_in);
         cyc(2);
         oc = force_exp(oc, compare_output_mode_in);
         chk(compare_output_out, oc);
      end
      chk(compare_flag_out, 8'h00);
      for (int m = 0; m < 4; m++) begin
         waveform_mode_in = 2'(m);
         cyc(2);
         chk(compare_output_out, oc);
      end
      done("force and hold");
      waveform_mode_in = timer8_pkg::MODE_CTC;
      compare_output_mode_in = timer8_pkg::COM_NONE;
      c = 8'h04 + 8'($random(seed) & 32'h0F);
      wr_cmp(c);
      wr_cnt(8'h00);
      clock_select_in = timer8_pkg::CS_DIV1;
      top = 8'h00;
      repeat (3 * (c + 1) + 10) begin
         @(negedge clk_sys_in);
         if (counter_value_out > top) top = counter_value_out;
      end
      chk(top, c);
      done("clear on match");
      clock_select_in = timer8_pkg::CS_STOP;
      waveform_mode_in = timer8_pkg::MODE_NORMAL;
      wr_cmp(8'h10);
      cyc(2);
      waveform_mode_in = timer8_pkg::MODE_FAST_PWM;
      wr_cmp(8'h80);
      cyc(2);
      chk(compare_value_out, 8'h80);
      wr_cnt(8'h00);
      pulse(compare_flag_clr_in);
      clock_select_in = timer8_pkg::CS_DIV1;
      wait_sig(1);
      chk(counter_value_out, 8'h11);
      pulse(compare_irq_ack_in);
      wait_sig(1);
      chk(counter_value_out, 8'h81);
      compare_output_mode_in = timer8_pkg::COM_CLEAR;
      wait_sig(2);
      cyc(2);
      chk(compare_output_out, 8'h01);
      cyc(128);
      chk(compare_output_out, 8'h00);
      done("buffered compare");
      waveform_mode_in = timer8_pkg::MODE_PC_PWM;
      wr_cnt(8'hF0);
      wait_sig(2);
      cyc(3);
      chk(counter_value_out, 8'hFC);
      done("dual slope");
      waveform_mode_in = timer8_pkg::MODE_NORMAL;
      for (int k = 6; k < 8; k++) begin
         clock_select_in = timer8_pkg::CS_STOP;
         wr_cnt(8'h00);
         clock_select_in = 3'(k);
         cyc(2);
         repeat (5) begin
            ext_count_pin_in = 1'b1;
            cyc(4);
            ext_count_pin_in = 1'b0;
            cyc(4);
         end
         cyc(8);
         chk(counter_value_out, 8'h05);
      end
      done("count pin");
      for (int k = 2; k < 6; k++) begin
         clock_select_in = timer8_pkg::CS_STOP;
         wr_cnt(8'h00);
         clock_select_in = 3'(k);
         cyc(3 * div_of(3'(k)));
         chk(counter_value_out, 8'h02);
         cyc(4);
         chk(counter_value_out, 8'h03);
      end
      done("prescaler");
      summarize();
   end
endmodule
